// [hw/cms_pkg.sv]
// Sequencer package: register map, field layouts, codes and timing.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package cms_pkg;
    // ----------------
    // Register map (byte addresses)
    // ----------------
    localparam logic [7:0] CMS_ADDR_LIMIT = 8'h00;
    localparam logic [7:0] CMS_ADDR_CHARGE = 8'h04;
    localparam logic [7:0] CMS_ADDR_CONTROL = 8'h08;
    localparam logic [7:0] CMS_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] CMS_ADDR_TIMER = 8'h10;
    localparam int CMS_ADDR_W = 8;

    // ----------------
    // Input limit codes, in milliamps order
    // ----------------
    localparam logic [2:0] CMS_LIM_100 = 3'h0;
    localparam logic [2:0] CMS_LIM_150 = 3'h1;
    localparam logic [2:0] CMS_LIM_300 = 3'h2;
    localparam logic [2:0] CMS_LIM_500 = 3'h3;
    localparam logic [2:0] CMS_LIM_900 = 3'h4;
    localparam logic [2:0] CMS_LIM_1500 = 3'h5;
    localparam logic [2:0] CMS_LIM_MAX = CMS_LIM_1500;

    // Charge current field defaults.
    localparam logic [4:0] CMS_TRICKLE_RST = 5'h01;
    localparam logic [4:0] CMS_WEAK_RST = 5'h02;    // Code for 20 mA in the weak phase.
    localparam int CMS_TRK_LSB = 0;
    localparam int CMS_WEAK_LSB = 8;

    // Control register bits.
    localparam int CMS_CTL_CHG_EN = 0;
    localparam int CMS_CTL_RECOVER = 1;
    localparam int CMS_CTL_PIN1_EN = 2;
    localparam int CMS_CTL_PIN3_EN = 3;
    localparam logic [3:0] CMS_CTL_RST = 4'h1;

    // Status register bit positions.
    localparam int CMS_ST_STATE_LSB = 0;
    localparam int CMS_ST_INPUT_LIMIT_SELECT = 4;
    localparam int CMS_ST_ISO = 5;
    localparam int CMS_ST_CUR_LIM_LSB = 8;

    // Charge state codes reported to software.
    localparam logic [2:0] CMS_CS_OFF = 3'h0;
    localparam logic [2:0] CMS_CS_TRICKLE = 3'h1;
    localparam logic [2:0] CMS_CS_WEAK = 3'h3;
    localparam logic [2:0] CMS_CS_FAULT = 3'h6;
    localparam logic [2:0] CMS_CS_READY = 3'h7;

    // ----------------
    // Timing
    // ----------------
    localparam int CMS_TRICKLE_MIN = 60;
    localparam int CMS_PRESCALE_DEF = 100_000_000;  // One tick per second.
    localparam int CMS_TRICKLE_TICKS = CMS_TRICKLE_MIN * 60;
    localparam int CMS_TICK_W = 12;
    localparam int CMS_DIV_W = 27;

    localparam logic [1:0] CMS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CMS_RESP_SLVERR = 2'h2;

    // Charger phase, one-hot.
    typedef enum logic [3:0]
    {
        CMS_PH_IDLE = 4'h1,
        CMS_PH_TRICKLE = 4'h2,
        CMS_PH_WEAK = 4'h4,
        CMS_PH_FAULT = 4'h8
    } cms_phase_t;
endpackage

// [hw/cms_tick_div.sv]
// Divider that produces a one-cycle tick for the trickle timer.
// Assumes the sequencer's clock and synchronous active-low reset.
module cms_tick_div #(
    parameter int DIVIDE = cms_pkg::CMS_PRESCALE_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    import cms_pkg::*;

    localparam logic [CMS_DIV_W-1:0] LAST = CMS_DIV_W'(DIVIDE - 1);

    logic [CMS_DIV_W-1:0] count_reg, count_next;
    logic tick_reg, tick_next;

    // ----------------
    // Count
    // ----------------
    // The count restarts whenever the timer is stopped, so each phase entry sees a full first period.
    always_comb
    begin
        count_next = count_reg;
        tick_next = 1'b0;
        if (!run)
        begin
            count_next = '0;
        end
        else if (count_reg == LAST)
        begin
            count_next = '0;
            tick_next = 1'b1;
        end
        else
        begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// [hw/cms_top.sv]
// Charge mode sequencer: input limit selection, trickle and weak phases, trickle timeout.
// Assumes asynchronous pin and comparator inputs and a 32-bit AXI4-Lite master.
//
// Function
// - Input limit follows software limit select field.
// - Pin one selects 100 or 500 mA.
// - Pin three can select 1500 mA.
// - Non-default software limit overrides all pins.
// - Limit resets to 100 mA.
// - Field codes 100,150,300,500,900,1500 mA.
// - Set input-limited flag when current starved while charging.
// - Below dead threshold, trickle at trickle current.
// - Report trickle in charge state field.
// - Isolation switch off during trickle.
// - Trickle over 60 minutes: stop, report fault.
// - Fault holds until software recovery.
// - Between dead and weak thresholds: weak phase.
// - Weak phase keeps input limit at 100 mA.
// - Weak current defaults to 20 mA.
// - Thermistor out of range stops charging.
module cms_top #(
    parameter int PRESCALE = cms_pkg::CMS_PRESCALE_DEF,
    parameter int TRICKLE_TICKS = cms_pkg::CMS_TRICKLE_TICKS
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [cms_pkg::CMS_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cms_pkg::CMS_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CONFIG_PIN_ONE,
    input wire logic CONFIG_PIN_THREE,
    input wire logic BAT_ABOVE_DEAD,
    input wire logic BAT_ABOVE_WEAK,
    input wire logic TEMP_OK,
    input wire logic INPUT_GOOD_LEVEL,
    input wire logic CURRENT_STARVED,
    output logic [2:0] INPUT_LIMIT,
    output logic CHARGE_ON,
    output logic TRICKLE_ON,
    output logic ISO_SWITCH_ON,
    output logic [4:0] CHARGE_CURRENT
);
    import cms_pkg::*;

    localparam int SYNC_W = 7;
    localparam logic [CMS_TICK_W-1:0] TRK_LAST = CMS_TICK_W'(TRICKLE_TICKS);

    // ----------------
    // Input synchronisers
    // ----------------
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic pin_one, pin_three, above_dead, above_weak, temp_ok, input_good, starved;

    // Every pin input passes two flops; only the second stage is read.
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {CONFIG_PIN_ONE, CONFIG_PIN_THREE, BAT_ABOVE_DEAD, BAT_ABOVE_WEAK,
                          TEMP_OK, INPUT_GOOD_LEVEL, CURRENT_STARVED};
            sync2_reg <= sync1_reg;
        end
    end

    assign {pin_one, pin_three, above_dead, above_weak, temp_ok, input_good, starved} = sync2_reg;

    // ----------------
    // Register bus
    // ----------------
    logic [2:0] limit_reg, limit_next;
    logic sw_override_reg, sw_override_next;
    logic [4:0] trk_cur_reg, trk_cur_next;
    logic [4:0] weak_cur_reg, weak_cur_next;
    logic [3:0] ctl_reg, ctl_next;
    logic recover_reg, recover_next;
    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    logic [CMS_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic input_limit_select_flag_reg, input_limit_select_flag_next;
    cms_phase_t phase_reg, phase_next;
    logic [CMS_TICK_W-1:0] trk_ticks_reg, trk_ticks_next;
    logic tick;
    logic [2:0] state_code;

    // Known register offsets.
    function automatic logic addr_ok(input logic [CMS_ADDR_W-1:0] a);
        addr_ok = (a == CMS_ADDR_LIMIT) || (a == CMS_ADDR_CHARGE) || (a == CMS_ADDR_CONTROL)
                  || (a == CMS_ADDR_STATUS) || (a == CMS_ADDR_TIMER);
    endfunction

    // Address and data are latched independently; the write commits once both are present.
    always_comb
    begin
        logic do_wr;
        do_wr = 1'b0;
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        limit_next = limit_reg;
        sw_override_next = sw_override_reg;
        trk_cur_next = trk_cur_reg;
        weak_cur_next = weak_cur_reg;
        ctl_next = ctl_reg;
        recover_next = 1'b0;
        if (S_AXI_AWVALID && !aw_full_reg)
        begin
            aw_full_next = 1'b1;
            awaddr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_full_reg)
        begin
            w_full_next = 1'b1;
            wdata_next = S_AXI_WDATA;
            wstrb_next = S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            bvalid_next = 1'b0;
        end
        if (aw_full_reg && w_full_reg && !bvalid_reg)
        begin
            do_wr = 1'b1;
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = addr_ok(awaddr_reg) ? CMS_RESP_OKAY : CMS_RESP_SLVERR;
        end
        if (do_wr && wstrb_reg[0])
        begin
            unique case (awaddr_reg)
                CMS_ADDR_LIMIT:
                begin
                    // Codes above the last defined step clamp to 1500 mA.
                    limit_next = (wdata_reg[2:0] > CMS_LIM_MAX) ? CMS_LIM_MAX : wdata_reg[2:0];
                    // Any write that leaves the 100 mA default hands control to software.
                    if (wdata_reg[2:0] != CMS_LIM_100)
                    begin
                        sw_override_next = 1'b1;
                    end
                end
                CMS_ADDR_CHARGE:
                begin
                    trk_cur_next = wdata_reg[CMS_TRK_LSB +: 5];
                end
                CMS_ADDR_CONTROL:
                begin
                    ctl_next = wdata_reg[3:0];
                    recover_next = wdata_reg[CMS_CTL_RECOVER];
                    ctl_next[CMS_CTL_RECOVER] = 1'b0;
                end
                default:
                begin
                end
            endcase
        end
        if (do_wr && wstrb_reg[1] && awaddr_reg == CMS_ADDR_CHARGE)
        begin
            weak_cur_next = wdata_reg[CMS_WEAK_LSB +: 5];
        end
    end

    // Read side answers one cycle after the address is taken.
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            rvalid_next = 1'b0;
        end
        if (S_AXI_ARVALID && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = addr_ok(S_AXI_ARADDR) ? CMS_RESP_OKAY : CMS_RESP_SLVERR;
            rdata_next = '0;
            unique case (S_AXI_ARADDR)
                CMS_ADDR_LIMIT: rdata_next[2:0] = limit_reg;
                CMS_ADDR_CHARGE:
                begin
                    rdata_next[CMS_TRK_LSB +: 5] = trk_cur_reg;
                    rdata_next[CMS_WEAK_LSB +: 5] = weak_cur_reg;
                end
                CMS_ADDR_CONTROL: rdata_next[3:0] = ctl_reg;
                CMS_ADDR_STATUS:
                begin
                    rdata_next[CMS_ST_STATE_LSB +: 3] = state_code;
                    rdata_next[CMS_ST_INPUT_LIMIT_SELECT] = input_limit_select_flag_reg;
                    rdata_next[CMS_ST_ISO] = ISO_SWITCH_ON;
                    rdata_next[CMS_ST_CUR_LIM_LSB +: 3] = INPUT_LIMIT;
                end
                CMS_ADDR_TIMER: rdata_next[CMS_TICK_W-1:0] = trk_ticks_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            limit_reg <= CMS_LIM_100;
            sw_override_reg <= 1'b0;
            trk_cur_reg <= CMS_TRICKLE_RST;
            weak_cur_reg <= CMS_WEAK_RST;
            ctl_reg <= CMS_CTL_RST;
            recover_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= CMS_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= CMS_RESP_OKAY;
            rdata_reg <= '0;
        end
        else
        begin
            limit_reg <= limit_next;
            sw_override_reg <= sw_override_next;
            trk_cur_reg <= trk_cur_next;
            weak_cur_reg <= weak_cur_next;
            ctl_reg <= ctl_next;
            recover_reg <= recover_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign S_AXI_AWREADY = !aw_full_reg;
    assign S_AXI_WREADY = !w_full_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;

    // ----------------
    // Charge phase sequencer
    // ----------------
    cms_tick_div #(
        .DIVIDE(PRESCALE)
    ) u_div (
        .clk_sys(CLK_SYS),
        .reset_n(RESET_N),
        .run(phase_reg == CMS_PH_TRICKLE),
        .tick(tick)
    );

    logic [2:0] limit_out_reg, limit_out_next;
    logic chg_on_reg, chg_on_next;
    logic trk_on_reg, trk_on_next;
    logic iso_reg, iso_next;
    logic [4:0] cur_reg, cur_next;
    logic enabled;

    // Charging needs software enable, a good input and an in-range thermistor.
    assign enabled = ctl_reg[CMS_CTL_CHG_EN] && input_good && temp_ok;

    // Phase moves with the comparators; the fault phase is left only by recovery.
    always_comb
    begin
        phase_next = phase_reg;
        trk_ticks_next = trk_ticks_reg;
        unique case (phase_reg)
            CMS_PH_IDLE:
            begin
                if (enabled && !above_dead)
                begin
                    phase_next = CMS_PH_TRICKLE;
                end
                else if (enabled && !above_weak)
                begin
                    phase_next = CMS_PH_WEAK;
                end
            end
            CMS_PH_TRICKLE:
            begin
                if (!enabled)
                begin
                    phase_next = CMS_PH_IDLE;
                end
                else if (trk_ticks_reg >= TRK_LAST)
                begin
                    phase_next = CMS_PH_FAULT;
                end
                else if (above_dead)
                begin
                    phase_next = above_weak ? CMS_PH_IDLE : CMS_PH_WEAK;
                end
            end
            CMS_PH_WEAK:
            begin
                if (!enabled || above_weak || !above_dead)
                begin
                    phase_next = CMS_PH_IDLE;
                end
            end
            CMS_PH_FAULT:
            begin
                if (recover_reg)
                begin
                    phase_next = CMS_PH_IDLE;
                end
            end
        endcase
        // The timer counts only inside trickle and is cleared on any other phase.
        if (phase_next != CMS_PH_TRICKLE || phase_reg != CMS_PH_TRICKLE)
        begin
            trk_ticks_next = '0;
        end
        else if (tick)
        begin
            trk_ticks_next = trk_ticks_reg + 1'b1;
        end
    end

    // Outputs are decoded from the next phase so they change with it, still from flops.
    always_comb
    begin
        chg_on_next = (phase_next == CMS_PH_TRICKLE) || (phase_next == CMS_PH_WEAK);
        trk_on_next = (phase_next == CMS_PH_TRICKLE);
        iso_next = (phase_next == CMS_PH_WEAK);
        cur_next = (phase_next == CMS_PH_WEAK) ? weak_cur_reg : trk_cur_reg;
        // Pins only act until software leaves the default.
        if (sw_override_reg)
        begin
            limit_out_next = limit_reg;
        end
        else if (ctl_reg[CMS_CTL_PIN3_EN] && pin_three)
        begin
            limit_out_next = CMS_LIM_1500;
        end
        else if (ctl_reg[CMS_CTL_PIN1_EN])
        begin
            limit_out_next = pin_one ? CMS_LIM_500 : CMS_LIM_100;
        end
        else
        begin
            limit_out_next = limit_reg;
        end
        // The transceiver is unpowered in weak phase, so no enumeration above 100 mA.
        if (phase_next == CMS_PH_WEAK)
        begin
            limit_out_next = CMS_LIM_100;
        end
        // Starved while charging sets the flag; it holds until charging stops.
        input_limit_select_flag_next = chg_on_reg && (starved || input_limit_select_flag_reg);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            phase_reg <= CMS_PH_IDLE;
            trk_ticks_reg <= '0;
            limit_out_reg <= CMS_LIM_100;
            chg_on_reg <= 1'b0;
            trk_on_reg <= 1'b0;
            iso_reg <= 1'b0;
            cur_reg <= CMS_TRICKLE_RST;
            input_limit_select_flag_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            trk_ticks_reg <= trk_ticks_next;
            limit_out_reg <= limit_out_next;
            chg_on_reg <= chg_on_next;
            trk_on_reg <= trk_on_next;
            iso_reg <= iso_next;
            cur_reg <= cur_next;
            input_limit_select_flag_reg <= input_limit_select_flag_next;
        end
    end

    // Reported charge state code.
    always_comb
    begin
        unique case (phase_reg)
            CMS_PH_TRICKLE: state_code = CMS_CS_TRICKLE;
            CMS_PH_WEAK: state_code = CMS_CS_WEAK;
            CMS_PH_FAULT: state_code = CMS_CS_FAULT;
            default: state_code = enabled ? CMS_CS_READY : CMS_CS_OFF;
        endcase
    end

    assign INPUT_LIMIT = limit_out_reg;
    assign CHARGE_ON = chg_on_reg;
    assign TRICKLE_ON = trk_on_reg;
    assign ISO_SWITCH_ON = iso_reg;
    assign CHARGE_CURRENT = cur_reg;
endmodule

// [verification/cms_batt_model.sv]
// Battery side model: the two cell voltage comparators.
// Assumes the bench sets a coarse cell level: 0 dead, 1 weak, 2 healthy.
module cms_batt_model
(
    input wire logic clk_sys,
    input wire logic [1:0] level,
    output logic above_dead = 1'h1,
    output logic above_weak = 1'h1
);
    timeunit 1ns;
    timeprecision 1ps;
    // Comparators lag the cell by a clock, as a filtered comparator would.
    always @(posedge clk_sys)
    begin
        above_dead <= level != 2'h0;
        above_weak <= level > 2'h1;
    end
endmodule

// [verification/cms_checker.sv]
// Port-level properties of the charge mode sequencer.
// Assumes it is bound to cms_top and sees only that module's ports.
module cms_checker
    import cms_pkg::*;
#(
    parameter int PRESCALE = 4,
    parameter int TRICKLE_TICKS = 5
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic TEMP_OK,
    input wire logic [2:0] INPUT_LIMIT,
    input wire logic CHARGE_ON,
    input wire logic TRICKLE_ON,
    input wire logic ISO_SWITCH_ON
);
    // Longest legal trickle dwell, with slack for divider phase and sync delay.
    localparam int TRK_MAX = PRESCALE * (TRICKLE_TICKS + 2) + 8;
    int trk_cnt_reg, trk_cnt_next;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);

    // Trickle dwell counter; a timer that never fires shows up here.
    always_comb trk_cnt_next = TRICKLE_ON ? trk_cnt_reg + 1 : 0;
    always_ff @(posedge CLK_SYS) trk_cnt_reg <= RESET_N ? trk_cnt_next : 0;

    property p_iso;
        TRICKLE_ON |-> !ISO_SWITCH_ON;
    endproperty
    a_iso: assert property (p_iso) else $error("isolation switch on in trickle");
    property p_trk_chg;
        TRICKLE_ON |-> CHARGE_ON;
    endproperty
    a_trk_chg: assert property (p_trk_chg) else $error("trickle without charging");
    property p_trk_max;
        TRICKLE_ON |-> trk_cnt_reg <= TRK_MAX;
    endproperty
    a_trk_max: assert property (p_trk_max) else $error("trickle outlived its timer");
    property p_wk;
        ISO_SWITCH_ON |-> CHARGE_ON && !TRICKLE_ON;
    endproperty
    a_wk: assert property (p_wk) else $error("weak phase outputs inconsistent");
    property p_wk_lim;
        ISO_SWITCH_ON |-> INPUT_LIMIT == CMS_LIM_100;
    endproperty
    a_wk_lim: assert property (p_wk_lim) else $error("weak phase limit not lowest");
    property p_temp;
        !TEMP_OK [*6] |-> !CHARGE_ON;
    endproperty
    a_temp: assert property (p_temp) else $error("charging while too hot");
    property p_lim_rng;
        INPUT_LIMIT <= CMS_LIM_MAX;
    endproperty
    a_lim_rng: assert property (p_lim_rng) else $error("limit code out of range");
    property p_rdone;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read response repeated");
endmodule

bind cms_top cms_checker #(.PRESCALE(PRESCALE), .TRICKLE_TICKS(TRICKLE_TICKS)) cms_checker_i (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .TEMP_OK(TEMP_OK), .INPUT_LIMIT(INPUT_LIMIT), .CHARGE_ON(CHARGE_ON), .TRICKLE_ON(TRICKLE_ON),
    .ISO_SWITCH_ON(ISO_SWITCH_ON)
);

// [verification/tb_charge_mode_sequencer.sv]
// Bench for the charge mode sequencer.
// Assumes a short tick divider for a quick trickle timeout.
module tb_charge_mode_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import cms_pkg::*;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic pin1 = 1'h0, pin3 = 1'h0, temp_ok = 1'h1, in_good = 1'h1, starved = 1'h0;
    logic [1:0] level = 2'h2;
    logic awready, wready, bvalid, arready, rvalid, chg_on, trk_on, iso_on, above_dead, above_weak;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata;
    logic [2:0] in_lim;
    logic [4:0] chg_cur;
    int n_fail = 0, checks_done = 0;

    // Free-running system clock.
    always #5 clk_sys = ~clk_sys;

    cms_top #(.PRESCALE(4), .TRICKLE_TICKS(5)) cms_top_i (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CONFIG_PIN_ONE(pin1),
        .CONFIG_PIN_THREE(pin3), .BAT_ABOVE_DEAD(above_dead), .BAT_ABOVE_WEAK(above_weak),
        .TEMP_OK(temp_ok), .INPUT_GOOD_LEVEL(in_good), .CURRENT_STARVED(starved), .INPUT_LIMIT(in_lim),
        .CHARGE_ON(chg_on), .TRICKLE_ON(trk_on), .ISO_SWITCH_ON(iso_on), .CHARGE_CURRENT(chg_cur)
    );
    cms_batt_model cms_batt_model_i (.clk_sys(clk_sys), .level(level), .above_dead(above_dead),
        .above_weak(above_weak));

    // Closing verdict; the only place the run ends.
    task automatic stop_test;
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bus master: AW and W offered together, each dropped once taken; only the watchdog ends a wait.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (bvalid !== 1'h1)
        begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        chk("write response", 32'(CMS_RESP_OKAY), 32'(bresp));
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (rvalid !== 1'h1)
        begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'h0;
        end
        rr = rresp;
        rready <= 1'h0;
        chk(name, exp, rdata & m);
    endtask
    // Two sync flops, phase and output flop, plus margin.
    task automatic settle;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic t_reset;
        chk("limit after reset", 32'(CMS_LIM_100), 32'(in_lim));
        rchk("limit reg", CMS_ADDR_LIMIT, 32'h7, 32'h0);
        rchk("charge reg", CMS_ADDR_CHARGE, 32'h1f1f, {19'h0, CMS_WEAK_RST, 3'h0, CMS_TRICKLE_RST});
        rchk("unmapped", 8'h14, 32'hffffffff, 32'h0);
        chk("unmapped resp", 32'(CMS_RESP_SLVERR), 32'(rr));
    endtask
    task automatic t_pins;
        wr(CMS_ADDR_CONTROL, 32'hd);
        pin1 <= 1'h1;
        settle();
        chk("pin one high", 32'(CMS_LIM_500), 32'(in_lim));
        pin3 <= 1'h1;
        settle();
        chk("pin three", 32'(CMS_LIM_1500), 32'(in_lim));
        pin1 <= 1'h0;
        pin3 <= 1'h0;
        settle();
        chk("pin one low", 32'(CMS_LIM_100), 32'(in_lim));
    endtask
    // Software codes beat pins asking for the most.
    task automatic t_sw;
        pin1 <= 1'h1;
        pin3 <= 1'h1;
        for (int k = 1; k <= 5; k++)
        begin
            wr(CMS_ADDR_LIMIT, 32'(k));
            settle();
            chk("software limit", 32'(k), 32'(in_lim));
        end
        wr(CMS_ADDR_LIMIT, 32'h0);
        settle();
        chk("software lowest", 32'(CMS_LIM_100), 32'(in_lim));
    endtask
    task automatic t_weak;
        wr(CMS_ADDR_LIMIT, 32'(CMS_LIM_900));
        starved <= 1'h1;
        level <= 2'h1;
        settle();
        chk("weak limit", 32'(CMS_LIM_100), 32'(in_lim));
        chk("weak current", 32'(CMS_WEAK_RST), 32'(chg_cur));
        rchk("weak status", CMS_ADDR_STATUS, 32'h737, {21'h0, CMS_LIM_100, 5'h6, CMS_CS_WEAK});
        temp_ok <= 1'h0;
        settle();
        chk("hot stop", 32'h0, 32'(chg_on));
        temp_ok <= 1'h1;
        starved <= 1'h0;
        settle();
        chk("cool resume", 32'h1, 32'(iso_on));
    endtask
    task automatic t_trickle;
        wr(CMS_ADDR_CONTROL, 32'hc);
        level <= 2'h0;
        wr(CMS_ADDR_CONTROL, 32'hd);
        settle();
        chk("trickle on", 32'h1, 32'(trk_on));
        chk("trickle iso", 32'h0, 32'(iso_on));
        rchk("trickle state", CMS_ADDR_STATUS, 32'h7, 32'(CMS_CS_TRICKLE));
        for (int i = 0; i < 60 && chg_on === 1'h1; i++) @(posedge clk_sys);
        rchk("fault state", CMS_ADDR_STATUS, 32'h7, 32'(CMS_CS_FAULT));
        level <= 2'h1;
        settle();
        chk("fault holds", 32'h0, 32'(chg_on));
        wr(CMS_ADDR_CONTROL, 32'hf);
        settle();
        rchk("recovered", CMS_ADDR_STATUS, 32'h7, 32'(CMS_CS_WEAK));
        rchk("timer cleared", CMS_ADDR_TIMER, 32'hfff, 32'h0);
    endtask

    // Main sequence after a 12-cycle reset.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'h1;
        t_reset();
        t_pins();
        t_sw();
        t_weak();
        t_trickle();
        stop_test();
    end
    // Watchdog: the whole run needs well under 5000 cycles.
    initial
    begin
        #50000;
        n_fail++;
        stop_test();
    end
endmodule
